// ---- shared/aemac_regs.vh ----
// Purpose: Constants for the address extension and MAC unit
// Assumes: 200 MHz core clock
// Notes:   Offsets index the plain register port
`ifndef AEMAC_REGS_VH
`define AEMAC_REGS_VH
// =====================================================
// Register offsets
`define AEMAC_OFF_KPACK    4'h0
`define AEMAC_OFF_STACKK   4'h1
`define AEMAC_OFF_CCR      4'h2
`define AEMAC_OFF_MASK     4'h3
`define AEMAC_OFF_XPTR     4'h4
`define AEMAC_OFF_YPTR     4'h5
`define AEMAC_OFF_ACCLO    4'h6
`define AEMAC_OFF_ACCHI    4'h7
`define AEMAC_OFF_STATUS   4'h8
// =====================================================
// Field positions
`define AEMAC_KP_X_LSB     12
`define AEMAC_KP_Y_LSB     8
`define AEMAC_KP_Z_LSB     4
`define AEMAC_KP_E_LSB     0
`define AEMAC_CCR_SM_BIT   4
`define AEMAC_CCR_EV_BIT   5
`define AEMAC_CCR_MV_BIT   6
// =====================================================
// Reset values
`define AEMAC_RST_NIB      4'h0
`define AEMAC_RST_WORD     16'h0000
`define AEMAC_RST_ACC      36'h000000000
// =====================================================
// Selectors and constants
`define AEMAC_SEL_X        3'h0
`define AEMAC_SEL_Y        3'h1
`define AEMAC_SEL_Z        3'h2
`define AEMAC_SEL_E        3'h3
`define AEMAC_SEL_S        3'h4
`define AEMAC_SAT_POS      16'h7fff
`define AEMAC_SAT_NEG      16'h8000
`define AEMAC_MAC_NS       60
`define AEMAC_CLK_NS       5
`define AEMAC_MAC_CYC      (`AEMAC_MAC_NS / `AEMAC_CLK_NS)
`endif

// ---- verilog/aemac_modptr.v ----
// Purpose: Modulo pointer step for the MAC index pointers
// Assumes: Table aligned to its mask-defined size
// Notes:   Zero mask leaves the pointer unrestricted
`timescale 1ns/10ps
module aemac_modptr
(
  input  wire [15:0] ptr,
  input  wire [7:0]  mask,
  input  wire [4:0]  step,
  output wire [15:0] next_ptr
);
  wire [15:0] sum;
  wire [15:0] wmask;
  wire [7:0]  fill;
  // =====================================================
  // Wrap mask from highest set bit
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_fill
      assign fill[i] = |mask[7:i];
    end
  endgenerate
  assign wmask    = (mask == 8'h00) ? 16'hffff : {8'h00, fill};
  assign sum      = ptr + {{11{step[4]}}, step};
  assign next_ptr = (ptr & ~wmask) | (sum & wmask);
endmodule

// ---- verilog/aemac_core.v ----
// Purpose: Address extension banks and multiply-accumulate datapath
// Assumes: Decoder pulses one command per cycle; memory answers at once
// Notes:   Registers reached over a plain address/strobe port
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "aemac_regs.vh"
module aemac_core
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        pc_step,
  input  wire        stack_pull,
  input  wire [15:0] stack_ccr,
  input  wire [15:0] stack_pc,
  input  wire        b_to_bank_xfer,
  input  wire        bank_to_b_xfer,
  input  wire [2:0]  xfer_sel,
  input  wire [7:0]  acc_b,
  output reg  [7:0]  b_result,
  output reg         b_result_valid,
  input  wire        direct_req,
  input  wire [15:0] direct_addr,
  input  wire        ey_req,
  input  wire [15:0] acc_e,
  input  wire        ptr_req,
  input  wire [2:0]  ptr_sel,
  input  wire [15:0] ptr_ea,
  input  wire        mac_start,
  input  wire [4:0]  mac_x_step,
  input  wire [4:0]  mac_y_step,
  input  wire [15:0] mem_rdata,
  output reg  [19:0] mem_addr,
  output reg         mem_req,
  output reg         mem_prog,
  output reg  [19:0] prog_addr,
  output wire        mac_busy,
  output reg         mac_done
);
  reg  [3:0]  x_bank_ext;
  reg  [3:0]  y_bank_ext;
  reg  [3:0]  z_bank_ext;
  reg  [3:0]  pc_bank_ext;
  reg  [3:0]  stack_bank_ext;
  reg  [3:0]  acc_direct_bank_ext;
  reg  [15:0] pc;
  reg  [15:0] cond_code_reg;
  reg  [7:0]  x_modulo_mask;
  reg  [7:0]  y_modulo_mask;
  reg  [15:0] x_ptr;
  reg  [15:0] y_pointer;
  reg  [35:0] accum;
  reg         sign_latch;
  reg  [15:0] op_x;
  reg  [15:0] op_y;
  reg  [3:0]  mac_cnt;
  reg  [1:0]  state;
  wire [15:0] k_packed;
  wire [16:0] ey_sum;
  wire [15:0] next_x;
  wire [15:0] next_y;
  wire [31:0] product;
  wire [35:0] next_acc;
  wire        ovf31;
  wire        ovf35;
  wire        saturate_enable;
  wire        ext_overflow_flag;
  wire        accum_overflow_flag;
  localparam ST_IDLE = 2'h0;
  localparam ST_RDX  = 2'h1;
  localparam ST_RDY  = 2'h2;
  localparam ST_RUN  = 2'h3;
  // =====================================================
  // Extension select
  function [3:0] bank_of;
    input [2:0] sel;
    input [3:0] xk;
    input [3:0] yk;
    input [3:0] zk;
    input [3:0] ek;
    input [3:0] sk;
    begin
      case (sel)
        `AEMAC_SEL_X: bank_of = xk;
        `AEMAC_SEL_Y: bank_of = yk;
        `AEMAC_SEL_Z: bank_of = zk;
        `AEMAC_SEL_E: bank_of = ek;
        `AEMAC_SEL_S: bank_of = sk;
        default:      bank_of = 4'h0;
      endcase
    end
  endfunction
  // =====================================================
  // Combinational datapath
  assign k_packed = {x_bank_ext, y_bank_ext, z_bank_ext, acc_direct_bank_ext};
  assign ey_sum   = {1'b0, acc_e} + {1'b0, y_pointer};
  assign product  = $signed(op_x) * $signed(op_y);
  assign next_acc = accum + {{4{product[31]}}, product};
  assign ovf31    = (next_acc[35:31] != {5{next_acc[35]}});
  assign ovf35    = (accum[35] == product[31]) && (next_acc[35] != accum[35]);
  assign saturate_enable     = cond_code_reg[`AEMAC_CCR_SM_BIT];
  assign ext_overflow_flag   = cond_code_reg[`AEMAC_CCR_EV_BIT];
  assign accum_overflow_flag = cond_code_reg[`AEMAC_CCR_MV_BIT];
  assign mac_busy = (state != ST_IDLE);
  aemac_modptr u_modx
  (
    .ptr      (x_ptr),
    .mask     (x_modulo_mask),
    .step     (mac_x_step),
    .next_ptr (next_x)
  );
  aemac_modptr u_mody
  (
    .ptr      (y_pointer),
    .mask     (y_modulo_mask),
    .step     (mac_y_step),
    .next_ptr (next_y)
  );
  // =====================================================
  // Program counter and its extension
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pc          <= `AEMAC_RST_WORD;
      pc_bank_ext <= `AEMAC_RST_NIB;
      prog_addr   <= 20'h00000;
    end
    else if (ce)
    begin
      if (stack_pull)
      begin
        pc          <= stack_pc;
        pc_bank_ext <= stack_ccr[3:0];
      end
      else if (pc_step)
        {pc_bank_ext, pc} <= {pc_bank_ext, pc} + 20'h00002;
      prog_addr <= {pc_bank_ext, pc};
    end
  end
  // =====================================================
  // Bank registers, masks, B transfer, bus answer
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      x_bank_ext          <= `AEMAC_RST_NIB;
      y_bank_ext          <= `AEMAC_RST_NIB;
      z_bank_ext          <= `AEMAC_RST_NIB;
      stack_bank_ext      <= `AEMAC_RST_NIB;
      acc_direct_bank_ext <= `AEMAC_RST_NIB;
      x_modulo_mask       <= 8'h00;
      y_modulo_mask       <= 8'h00;
      b_result            <= 8'h00;
      b_result_valid      <= 1'b0;
      reg_rdata           <= `AEMAC_RST_WORD;
    end
    else if (ce)
    begin
      b_result_valid <= bank_to_b_xfer;
      if (bank_to_b_xfer)
        b_result <= {4'h0, bank_of(xfer_sel, x_bank_ext, y_bank_ext, z_bank_ext,
                                   acc_direct_bank_ext, stack_bank_ext)};
      if (b_to_bank_xfer)
      begin
        case (xfer_sel)
          `AEMAC_SEL_X: x_bank_ext          <= acc_b[3:0];
          `AEMAC_SEL_Y: y_bank_ext          <= acc_b[3:0];
          `AEMAC_SEL_Z: z_bank_ext          <= acc_b[3:0];
          `AEMAC_SEL_E: acc_direct_bank_ext <= acc_b[3:0];
          `AEMAC_SEL_S: stack_bank_ext      <= acc_b[3:0];
          default:      stack_bank_ext      <= stack_bank_ext;
        endcase
      end
      else if (reg_wr && reg_addr == `AEMAC_OFF_KPACK)
      begin
        x_bank_ext          <= reg_wdata[`AEMAC_KP_X_LSB+3:`AEMAC_KP_X_LSB];
        y_bank_ext          <= reg_wdata[`AEMAC_KP_Y_LSB+3:`AEMAC_KP_Y_LSB];
        z_bank_ext          <= reg_wdata[`AEMAC_KP_Z_LSB+3:`AEMAC_KP_Z_LSB];
        acc_direct_bank_ext <= reg_wdata[`AEMAC_KP_E_LSB+3:`AEMAC_KP_E_LSB];
      end
      else if (reg_wr && reg_addr == `AEMAC_OFF_STACKK)
        stack_bank_ext <= reg_wdata[3:0];
      if (reg_wr && reg_addr == `AEMAC_OFF_MASK)
      begin
        x_modulo_mask <= reg_wdata[15:8];
        y_modulo_mask <= reg_wdata[7:0];
      end
      reg_rdata <= `AEMAC_RST_WORD;
      if (reg_rd)
      begin
        case (reg_addr)
          `AEMAC_OFF_KPACK:  reg_rdata <= k_packed;
          `AEMAC_OFF_STACKK: reg_rdata <= {12'h000, stack_bank_ext};
          `AEMAC_OFF_CCR:    reg_rdata <= {cond_code_reg[15:4], pc_bank_ext};
          `AEMAC_OFF_MASK:   reg_rdata <= {x_modulo_mask, y_modulo_mask};
          `AEMAC_OFF_XPTR:   reg_rdata <= x_ptr;
          `AEMAC_OFF_YPTR:   reg_rdata <= y_pointer;
          `AEMAC_OFF_ACCLO:  reg_rdata <= accum[15:0];
          `AEMAC_OFF_ACCHI:  reg_rdata <= accum[31:16];
          `AEMAC_OFF_STATUS: reg_rdata <= {11'h000, sign_latch, accum[35:32]};
          default:           reg_rdata <= `AEMAC_RST_WORD;
        endcase
      end
    end
  end
  // =====================================================
  // Memory address formation
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_addr <= 20'h00000;
      mem_req  <= 1'b0;
      mem_prog <= 1'b0;
    end
    else if (ce)
    begin
      mem_req  <= 1'b0;
      mem_prog <= 1'b0;
      if (state == ST_RDX)
      begin
        mem_req  <= 1'b1;
        mem_addr <= {x_bank_ext, x_ptr};
      end
      else if (state == ST_RDY)
      begin
        mem_req  <= 1'b1;
        mem_addr <= {y_bank_ext, y_pointer};
      end
      else if (ey_req)
      begin
        mem_req  <= 1'b1;
        mem_addr <= {y_bank_ext + {3'h0, ey_sum[16]}, ey_sum[15:0]};
      end
      else if (direct_req)
      begin
        mem_req  <= 1'b1;
        mem_addr <= {acc_direct_bank_ext, direct_addr};
      end
      else if (ptr_req)
      begin
        mem_req  <= 1'b1;
        mem_addr <= {bank_of(ptr_sel, x_bank_ext, y_bank_ext, z_bank_ext,
                             acc_direct_bank_ext, stack_bank_ext), ptr_ea};
      end
      else if (pc_step)
      begin
        mem_req  <= 1'b1;
        mem_prog <= 1'b1;
        mem_addr <= {pc_bank_ext, pc};
      end
    end
  end
  // =====================================================
  // Multiply-accumulate sequencer
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state         <= ST_IDLE;
      mac_cnt       <= 4'h0;
      mac_done      <= 1'b0;
      x_ptr         <= `AEMAC_RST_WORD;
      y_pointer     <= `AEMAC_RST_WORD;
      op_x          <= `AEMAC_RST_WORD;
      op_y          <= `AEMAC_RST_WORD;
      accum         <= `AEMAC_RST_ACC;
      sign_latch    <= 1'b0;
      cond_code_reg <= `AEMAC_RST_WORD;
    end
    else if (ce)
    begin
      mac_done <= 1'b0;
      if (reg_wr && reg_addr == `AEMAC_OFF_CCR)
        cond_code_reg <= {reg_wdata[15:4], 4'h0};
      if (reg_wr && reg_addr == `AEMAC_OFF_XPTR && state == ST_IDLE)
        x_ptr <= reg_wdata;
      if (reg_wr && reg_addr == `AEMAC_OFF_YPTR && state == ST_IDLE)
        y_pointer <= reg_wdata;
      if (reg_wr && reg_addr == `AEMAC_OFF_ACCLO && state == ST_IDLE)
        accum[15:0] <= reg_wdata;
      if (reg_wr && reg_addr == `AEMAC_OFF_ACCHI && state == ST_IDLE)
        accum[31:16] <= reg_wdata;
      case (state)
        ST_IDLE:
        begin
          if (mac_start)
          begin
            state   <= ST_RDX;
            mac_cnt <= 4'h0;
          end
        end
        ST_RDX:
        begin
          mac_cnt <= mac_cnt + 4'h1;
          state   <= ST_RDY;
        end
        ST_RDY:
        begin
          op_x    <= mem_rdata;
          mac_cnt <= mac_cnt + 4'h1;
          state   <= ST_RUN;
        end
        ST_RUN:
        begin
          if (mac_cnt == 4'h2)
            op_y <= mem_rdata;
          mac_cnt <= mac_cnt + 4'h1;
          if (mac_cnt == `AEMAC_MAC_CYC - 2)
          begin
            state     <= ST_IDLE;
            mac_done  <= 1'b1;
            x_ptr     <= next_x;
            y_pointer <= next_y;
            if (ovf31)
              cond_code_reg[`AEMAC_CCR_EV_BIT] <= 1'b1;
            if (ovf35)
            begin
              cond_code_reg[`AEMAC_CCR_MV_BIT] <= 1'b1;
              sign_latch <= accum[35];
            end
            if (saturate_enable && (ovf31 || ovf35 || ext_overflow_flag ||
                accum_overflow_flag))
              accum <= {{4{(ovf35 ? accum[35] : next_acc[35])}},
                        ((ovf35 ? accum[35] : next_acc[35]) ? `AEMAC_SAT_NEG
                        : `AEMAC_SAT_POS), next_acc[15:0]};
            else
              accum <= next_acc;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ---- tb/aemac_core_checker.sv ----
// Purpose: Port checker for the extension and MAC core
// Assumes: Single clock, ce low only while idle
// Notes:   Bound to every aemac_core instance
`timescale 1ns/10ps
module aemac_core_checker
(
  input logic        clk,
  input logic        rst_n,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        pc_step,
  input logic        stack_pull,
  input logic [15:0] stack_ccr,
  input logic [15:0] stack_pc,
  input logic        bank_to_b_xfer,
  input logic [7:0]  b_result,
  input logic        b_result_valid,
  input logic        direct_req,
  input logic [15:0] direct_addr,
  input logic        ey_req,
  input logic        ptr_req,
  input logic        mac_start,
  input logic [19:0] mem_addr,
  input logic        mem_req,
  input logic        mem_prog,
  input logic [19:0] prog_addr,
  input logic        mac_busy,
  input logic        mac_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // Helpers
  logic [19:0] pulled;
  wire         mac_on = mac_start || mac_busy;
  wire         quiet  = !(mac_on || ey_req || direct_req || ptr_req);
  wire         any_rq = !quiet || pc_step;
  always @(posedge clk)
  begin
    pulled <= {stack_ccr[3:0], stack_pc};
  end
  sequence s_busy_run;
    mac_busy [*8] ##1 mac_busy [*3];
  endsequence
  sequence s_finish;
    !mac_busy && mac_done;
  endsequence
  // ==================================================
  // Properties
  chk_mac_twelve: assert property (mac_start && !mac_busy |=> s_busy_run ##1 s_finish)
    else $error("mac did not finish in twelve cycles");
  chk_done_pulse: assert property (mac_done |=> !mac_done)
    else $error("mac done longer than one cycle");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without a read");
  chk_pc_carry: assert property (pc_step && !stack_pull && quiet ##1 !stack_pull
    |=> prog_addr == $past(prog_addr) + 20'h00002) else $error("pc step not plus two");
  chk_pull_load: assert property (stack_pull && !pc_step ##1 !stack_pull && !pc_step
    |=> prog_addr == $past(pulled)) else $error("unstack did not load pc");
  chk_pc_hold: assert property (!pc_step && !stack_pull ##1 1'b1 |=> $stable(prog_addr))
    else $error("pc moved without step or unstack");
  chk_pc_fetch: assert property (pc_step && quiet |=> mem_req && mem_prog)
    else $error("fetch not in program space");
  chk_direct_data: assert property (direct_req && !mac_on && !ey_req |=> mem_req && !mem_prog
    && mem_addr[15:0] == $past(direct_addr)) else $error("direct access address wrong");
  chk_ey_data: assert property (ey_req && !mac_on |=> mem_req && !mem_prog)
    else $error("offset access not in data space");
  chk_req_cause: assert property (mem_req |-> $past(any_rq))
    else $error("memory request without cause");
  chk_b_result: assert property (bank_to_b_xfer |=> b_result_valid && b_result[7:4] == 4'h0)
    else $error("bank read into b missing");
  chk_valid_cause: assert property (b_result_valid |-> $past(bank_to_b_xfer))
    else $error("b result without transfer");
endmodule
bind aemac_core aemac_core_checker u_chk
(
  .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_step(pc_step),
  .stack_pull(stack_pull), .stack_ccr(stack_ccr), .stack_pc(stack_pc),
  .bank_to_b_xfer(bank_to_b_xfer), .b_result(b_result), .b_result_valid(b_result_valid),
  .direct_req(direct_req), .direct_addr(direct_addr), .ey_req(ey_req), .ptr_req(ptr_req),
  .mac_start(mac_start), .mem_addr(mem_addr), .mem_req(mem_req), .mem_prog(mem_prog),
  .prog_addr(prog_addr), .mac_busy(mac_busy), .mac_done(mac_done)
);

// ---- tb/aemac_mem_model.sv ----
// Purpose: Core memory bus model, answers in the request cycle
// Assumes: Data is a function of the address
// Notes:   Outside requests the data lines toggle
`timescale 1ns/10ps
module aemac_mem_model
(
  input  logic        clk,
  input  logic        mem_req,
  input  logic [19:0] mem_addr,
  output logic [15:0] mem_rdata
);
  logic [15:0] last = 16'h0000;
  always @(posedge clk)
  begin
    last <= mem_rdata;
  end
  assign mem_rdata = mem_req ? {{2{mem_addr[13]}}, mem_addr[13:0]} : ~last;
endmodule

// ---- tb/test_address_extension_mac_unit.sv ----
// Purpose: Self-checking bench for the extension and MAC core
// Assumes: ce high except one freeze check, memory answers at once
// Notes:   Expected results queued by the driver
`timescale 1ns/10ps
`include "aemac_regs.vh"
module test_address_extension_mac_unit;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, rd_d = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, pc_step = 1'b0, stack_pull = 1'b0;
  logic        b_to_bank_xfer = 1'b0, bank_to_b_xfer = 1'b0, direct_req = 1'b0;
  logic        ey_req = 1'b0, ptr_req = 1'b0, mac_start = 1'b0;
  logic [2:0]  xfer_sel = 3'h0, ptr_sel = 3'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [4:0]  mac_x_step = 5'h00, mac_y_step = 5'h00;
  logic [7:0]  acc_b = 8'h00, b_result;
  logic [15:0] reg_wdata = 16'h0000, stack_ccr = 16'h0000, stack_pc = 16'h0000;
  logic [15:0] direct_addr = 16'h0000, acc_e = 16'h0000, ptr_ea = 16'h0000;
  logic [15:0] mem_rdata, reg_rdata, xp, yp;
  logic [19:0] mem_addr, prog_addr;
  logic        b_result_valid, mem_req, mem_prog, mac_busy, mac_done;
  logic [3:0]  ext [0:4];
  logic [15:0] rq [$];
  logic [19:0] mq [$];
  logic [7:0]  bq [$];
  logic [31:0] v;
  logic [16:0] sum;
  logic [35:0] acc = 36'h000000000;
  logic [15:0] mk;
  logic signed [31:0] pr;
  int          n_mismatch = 0, checks_done = 0, i, w;
  initial forever #2.5 clk = ~clk;
  aemac_core dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pc_step(pc_step), .stack_pull(stack_pull), .stack_ccr(stack_ccr), .stack_pc(stack_pc),
    .b_to_bank_xfer(b_to_bank_xfer), .bank_to_b_xfer(bank_to_b_xfer), .xfer_sel(xfer_sel),
    .acc_b(acc_b), .b_result(b_result), .b_result_valid(b_result_valid),
    .direct_req(direct_req), .direct_addr(direct_addr), .ey_req(ey_req), .acc_e(acc_e),
    .ptr_req(ptr_req), .ptr_sel(ptr_sel), .ptr_ea(ptr_ea), .mac_start(mac_start),
    .mac_x_step(mac_x_step), .mac_y_step(mac_y_step), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_req(mem_req), .mem_prog(mem_prog), .prog_addr(prog_addr),
    .mac_busy(mac_busy), .mac_done(mac_done));
  aemac_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  // ==================================================
  // Helpers
  function [15:0] nxt(input [15:0] p, input [7:0] m, input [4:0] s);
    logic [15:0] t;
    logic [15:0] f;
    t = p + {{11{s[4]}}, s};
    f = 16'h0000;
    for (int k = 0; k < 8; k++)
      if (m >= (8'h01 << k))
        f[k] = 1'b1;
    nxt = (m == 8'h00) ? t : ((p & ~f) | (t & f));
  endfunction
  task compare(input string what, input [19:0] e, input [19:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==================================================
  // Watcher
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (rd_d) compare("reg_rdata", {4'h0, rq.pop_front()}, {4'h0, reg_rdata});
    if (b_result_valid === 1'b1) compare("b_result", {12'h0, bq.pop_front()}, {12'h0, b_result});
    if (mem_req === 1'b1 && mem_prog === 1'b0) compare("mem_addr", mq.pop_front(), mem_addr);
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  // ==================================================
  // Scenarios
  initial
  begin
    void'($urandom(72));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 10; i++) rd((i == 9) ? 4'hf : i[3:0], 16'h0000);
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk);
      v = $urandom;
      b_to_bank_xfer <= 1'b1;
      xfer_sel <= i[2:0];
      acc_b <= v[7:0];
      ext[i] = v[3:0];
      @(posedge clk);
      b_to_bank_xfer <= 1'b0;
    end
    rd(`AEMAC_OFF_KPACK, {ext[0], ext[1], ext[2], ext[3]});
    rd(`AEMAC_OFF_STACKK, {12'h000, ext[4]});
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk);
      bank_to_b_xfer <= 1'b1;
      xfer_sel <= i[2:0];
      bq.push_back({4'h0, ext[i]});
      @(posedge clk);
      bank_to_b_xfer <= 1'b0;
    end
    for (i = 0; i < 6; i++)
    begin
      @(posedge clk);
      v = $urandom;
      direct_req <= (i == 5);
      ptr_req <= (i != 5);
      ptr_sel <= i[2:0];
      ptr_ea <= v[15:0];
      direct_addr <= v[15:0];
      mq.push_back({ext[(i == 5) ? 3 : i], v[15:0]});
    end
    @(posedge clk);
    direct_req <= 1'b0;
    ptr_req <= 1'b0;
    wr(`AEMAC_OFF_YPTR, 16'hffff);
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk);
      v = (i == 2) ? $urandom : i;
      sum = 17'h0ffff + {1'b0, v[15:0]};
      mq.push_back({ext[1] + {3'h0, sum[16]}, sum[15:0]});
      ey_req <= 1'b1;
      acc_e <= v[15:0];
    end
    @(posedge clk);
    ey_req <= 1'b0;
    rd(`AEMAC_OFF_KPACK, {ext[0], ext[1], ext[2], ext[3]});
    @(posedge clk);
    stack_pull <= 1'b1;
    stack_ccr <= 16'h0003;
    stack_pc <= 16'hfffe;
    @(posedge clk);
    stack_pull <= 1'b0;
    @(posedge clk);
    pc_step <= 1'b1;
    @(posedge clk);
    pc_step <= 1'b0;
    rd(`AEMAC_OFF_CCR, 16'h0004);
    wr(`AEMAC_OFF_CCR, 16'h001f);
    rd(`AEMAC_OFF_CCR, 16'h0014);
    v = $urandom;
    xp = {v[15:3], 3'h6};
    yp = {v[31:18], 2'h0};
    wr(`AEMAC_OFF_XPTR, xp);
    wr(`AEMAC_OFF_YPTR, yp);
    @(posedge clk);
    ce <= 1'b0;
    b_to_bank_xfer <= 1'b1;
    xfer_sel <= 3'h0;
    acc_b <= {4'h0, ~ext[0]};
    @(posedge clk);
    b_to_bank_xfer <= 1'b0;
    ce <= 1'b1;
    rd(`AEMAC_OFF_KPACK, {ext[0], ext[1], ext[2], ext[3]});
    for (i = 0; i < 3; i++)
    begin
      mk = (i == 1) ? 16'h0003 : ((i == 2) ? 16'h0500 : 16'h0700);
      wr(`AEMAC_OFF_MASK, mk);
      @(posedge clk);
      mac_start <= 1'b1;
      mac_x_step <= $urandom_range(30) - 15;
      mac_y_step <= $urandom_range(30) - 15;
      mq.push_back({ext[0], xp});
      mq.push_back({ext[1], yp});
      pr = $signed({{2{xp[13]}}, xp[13:0]}) * $signed({{2{yp[13]}}, yp[13:0]});
      acc = acc + {{4{pr[31]}}, pr};
      @(posedge clk);
      mac_start <= 1'b0;
      for (w = 0; w < 20 && mac_done !== 1'b1; w++) @(posedge clk);
      xp = nxt(xp, mk[15:8], mac_x_step);
      yp = nxt(yp, mk[7:0], mac_y_step);
    end
    rd(`AEMAC_OFF_ACCLO, acc[15:0]);
    rd(`AEMAC_OFF_ACCHI, acc[31:16]);
    rd(`AEMAC_OFF_STATUS, {12'h000, acc[35:32]});
    rd(`AEMAC_OFF_XPTR, xp);
    rd(`AEMAC_OFF_YPTR, yp);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`AEMAC_OFF_KPACK, 16'h0000);
    // ==================================================
    // Overflow into bit 31 with saturation on
    wr(`AEMAC_OFF_CCR, 16'h0010);
    wr(`AEMAC_OFF_ACCLO, 16'hffff);
    wr(`AEMAC_OFF_ACCHI, 16'h7fff);
    wr(`AEMAC_OFF_XPTR, 16'h0100);
    wr(`AEMAC_OFF_YPTR, 16'h0100);
    @(posedge clk);
    mac_start <= 1'b1;
    mq.push_back(20'h00100);
    mq.push_back(20'h00100);
    @(posedge clk);
    mac_start <= 1'b0;
    for (w = 0; w < 20 && mac_done !== 1'b1; w++) @(posedge clk);
    rd(`AEMAC_OFF_ACCHI, `AEMAC_SAT_POS);
    rd(`AEMAC_OFF_ACCLO, 16'hffff);
    rd(`AEMAC_OFF_CCR, 16'h0030);
    // ==================================================
    // Packed and stack extensions over the register port
    wr(`AEMAC_OFF_KPACK, 16'h5a3c);
    wr(`AEMAC_OFF_STACKK, 16'h0009);
    rd(`AEMAC_OFF_KPACK, 16'h5a3c);
    rd(`AEMAC_OFF_STACKK, 16'h0009);
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule
